// >>> hw/cbr_pkg.sv
// package: register offsets, reset values, field layouts and pin source codes
package cbr_pkg;
  localparam logic [7:0] OFS_RD_OPCODE = 8'h57;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h58;
  localparam logic [7:0] OFS_ADDR_MIDDLE = 8'h59;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h5a;
  localparam logic [7:0] OFS_BOOT_STATUS = 8'h5b;
  localparam logic [7:0] OFS_FILTER_WR = 8'h5c;
  localparam logic [7:0] OFS_SUPPLY_V = 8'h5e;
  localparam logic [7:0] OFS_PIN_DIR = 8'h60;
  localparam logic [7:0] OFS_PIN0_SEL = 8'h61;
  localparam logic [7:0] RST_RD_OPCODE = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int BIT_BOOT_DONE = 0;
  localparam int BIT_BOOT_CRC_ERR = 1;
  localparam int BIT_FIRST_COEF = 0;
  localparam int PIN_COUNT = 3;
  localparam int SEL_WIDTH = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_USER = 4'h2;
  localparam logic [3:0] SRC_MUTE_BOTH = 4'h3;
  localparam logic [3:0] SRC_MUTE_LEFT = 4'h4;
  localparam logic [3:0] SRC_MUTE_RIGHT = 4'h5;
  localparam logic [3:0] SRC_CLK_INVALID = 4'h6;
  localparam logic [3:0] SRC_WARNING = 4'h8;
  localparam logic [3:0] SRC_AUDIO_OUT = 4'h9;
  localparam logic [3:0] SRC_FAULT = 4'hb;
  localparam logic [3:0] SRC_MEM_DATA = 4'hc;

  // register read and write request from the control port decoder
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbr_req_t;

  // status and source levels from the rest of the device
  typedef struct packed {
    logic mute_left;
    logic mute_right;
    logic clk_invalid;
    logic warning_out_n;
    logic serial_audio_out;
    logic fault_out_n;
    logic mem_data_out;
  } cbr_src_t;
endpackage

// >>> hw/cbr_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/100ps
module cbr_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end
  assign o_q = q_ff;
endmodule // cbr_sync

// >>> hw/cbr_reg8.sv
// one eight-bit read-write register with reset value
`timescale 1ns/100ps
module cbr_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] BIT_MASK = 8'hff
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q
);
  logic [7:0] val_ff;
  logic [7:0] nxt_val;
  always_comb begin
    nxt_val = val_ff;
    if (i_we) begin
      nxt_val = i_wdata & BIT_MASK;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      val_ff <= RESET_VAL;
    end else begin
      val_ff <= nxt_val;
    end
  end
  assign o_q = val_ff;
endmodule // cbr_reg8

// >>> hw/cbr_regs.sv
// coefficient boot and pin select register slice with pin 0 source mux
//
// What this block does
// RQ1 - eight-bit read-write memory read opcode, reset value 03h, at 57h
// RQ2 - three read-write start-address bytes high, middle, low, each reset zero
// RQ3 - middle byte at 59h, low byte at 5Ah, after high byte at 58h
// RQ4 - read-only bit 0 of 5Bh sets when boot load finished, zero after reset
// RQ5 - read-only bit 1 of 5Bh reads 1 when boot checksum failed
// RQ6 - read-write bit 0 at 5Ch marks first filter coefficient write, resets zero
// RQ7 - read-only supply voltage code at 5Eh, volts equals code over 8.428
// RQ8 - bits 2..0 of 60h set pin directions, 1 output, reset input
// RQ9 - selector 0000 drives pin 0 low, 0010 drives user output bit
// RQ10 - selectors 0011, 0100, 0101 drive both, left, right auto-mute flags
// RQ11 - selector 0110 drives the invalid clock flag
// RQ12 - selector 1000 drives the active-low warning indication
// RQ13 - selector 1001 drives the serial audio output stream
// RQ14 - selector 1011 drives the active-low fault indication
// RQ15 - selector 1100 drives memory controller data output
// RQ16 - host should avoid reserved selector codes 0001, 0111, 1110, 1111
// RQ17 - load-source bit 0 takes coefficients from host, 1 from serial memory
// RQ18 - full three-byte address used only when wide address enable is set
// RQ19 - user pin values come from bits 2..0 of output-value register 65h
// RQ20 - reserved bits read zero and writes to them change nothing
// RQ21 - pin 0 source reaches pin only while its direction bit is output
`timescale 1ns/100ps
module cbr_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire cbr_pkg::cbr_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_boot_done,
  input wire logic i_boot_crc_err,
  input wire logic [7:0] i_supply_voltage_code,
  input wire logic i_load_from_memory,
  input wire logic i_wide_address_enable,
  input wire logic [2:0] i_user_pin_value,
  input wire cbr_pkg::cbr_src_t i_src,
  output logic [7:0] o_memory_read_opcode,
  output logic [23:0] o_boot_start_addr,
  output logic o_boot_from_memory,
  output logic o_filter_first_coef_mark,
  output logic o_pin0_out,
  output logic o_pin0_output_enable,
  output logic o_pin1_output_enable,
  output logic o_pin2_output_enable
);
  import cbr_pkg::*;

  logic [7:0] opcode_q;
  logic [7:0] addr_high_q;
  logic [7:0] addr_middle_q;
  logic [7:0] addr_low_q;
  logic [7:0] filter_wr_q;
  logic [7:0] pin_dir_q;
  logic [7:0] pin0_sel_q;
  logic [6:0] src_sync;
  logic done_sync;
  logic crc_sync;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] supply_ff;
  logic [7:0] nxt_supply;
  logic [7:0] opcode_ff;
  logic [7:0] nxt_opcode;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic boot_src_ff;
  logic nxt_boot_src;
  logic mark_ff;
  logic nxt_mark;
  logic pin0_ff;
  logic nxt_pin0;
  logic [2:0] oe_ff;
  logic [2:0] nxt_oe;
  logic pin0_src;

  function automatic logic wr_hit(input cbr_req_t r, input logic [7:0] a);
    wr_hit = r.wr_en && (r.addr == a);
  endfunction

  cbr_reg8 #(.RESET_VAL(RST_RD_OPCODE), .BIT_MASK(8'hff)) u_opcode ( // RQ1
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_hit(i_req, OFS_RD_OPCODE)),
    .i_wdata(i_req.wdata), .o_q(opcode_q));
  cbr_reg8 #(.RESET_VAL(RST_ZERO), .BIT_MASK(8'hff)) u_addr_high ( // RQ2
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_hit(i_req, OFS_ADDR_HIGH)),
    .i_wdata(i_req.wdata), .o_q(addr_high_q));
  cbr_reg8 #(.RESET_VAL(RST_ZERO), .BIT_MASK(8'hff)) u_addr_middle ( // RQ3
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_hit(i_req, OFS_ADDR_MIDDLE)),
    .i_wdata(i_req.wdata), .o_q(addr_middle_q));
  cbr_reg8 #(.RESET_VAL(RST_ZERO), .BIT_MASK(8'hff)) u_addr_low ( // RQ3
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_hit(i_req, OFS_ADDR_LOW)),
    .i_wdata(i_req.wdata), .o_q(addr_low_q));
  // reserved bits are masked at the write so they always read zero
  cbr_reg8 #(.RESET_VAL(RST_ZERO), .BIT_MASK(8'h01)) u_filter_wr ( // RQ6 RQ20
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_hit(i_req, OFS_FILTER_WR)),
    .i_wdata(i_req.wdata), .o_q(filter_wr_q));
  cbr_reg8 #(.RESET_VAL(RST_ZERO), .BIT_MASK(8'h07)) u_pin_dir ( // RQ8 RQ20
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_hit(i_req, OFS_PIN_DIR)),
    .i_wdata(i_req.wdata), .o_q(pin_dir_q));
  cbr_reg8 #(.RESET_VAL(RST_ZERO), .BIT_MASK(8'h0f)) u_pin0_sel ( // RQ20
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_hit(i_req, OFS_PIN0_SEL)),
    .i_wdata(i_req.wdata), .o_q(pin0_sel_q));

  // pin-side and other-domain sources are synchronised before use
  cbr_sync u_sync_done (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_boot_done), .o_q(done_sync));
  cbr_sync u_sync_crc (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_boot_crc_err), .o_q(crc_sync));
  cbr_sync u_sync_ml (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_src.mute_left), .o_q(src_sync[6]));
  cbr_sync u_sync_mr (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_src.mute_right), .o_q(src_sync[5]));
  cbr_sync u_sync_ck (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_src.clk_invalid), .o_q(src_sync[4]));
  cbr_sync u_sync_wn (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_src.warning_out_n), .o_q(src_sync[3]));
  cbr_sync u_sync_sa (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_src.serial_audio_out), .o_q(src_sync[2]));
  cbr_sync u_sync_fn (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_src.fault_out_n), .o_q(src_sync[1]));
  cbr_sync u_sync_md (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_d(i_src.mem_data_out), .o_q(src_sync[0]));

  // status and supply capture
  always_comb begin
    nxt_status = RST_ZERO;
    nxt_status[BIT_BOOT_DONE] = done_sync; // RQ4
    nxt_status[BIT_BOOT_CRC_ERR] = crc_sync; // RQ5
    nxt_supply = i_supply_voltage_code; // RQ7
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_ff <= RST_ZERO;
      supply_ff <= RST_ZERO;
    end else begin
      status_ff <= nxt_status;
      supply_ff <= nxt_supply;
    end
  end

  // read decode: unmapped offsets read zero
  always_comb begin
    nxt_rdata = RST_ZERO;
    nxt_rvalid = i_req.rd_en;
    case (i_req.addr)
      OFS_RD_OPCODE: nxt_rdata = opcode_q;
      OFS_ADDR_HIGH: nxt_rdata = addr_high_q;
      OFS_ADDR_MIDDLE: nxt_rdata = addr_middle_q;
      OFS_ADDR_LOW: nxt_rdata = addr_low_q;
      OFS_BOOT_STATUS: nxt_rdata = status_ff;
      OFS_FILTER_WR: nxt_rdata = filter_wr_q;
      OFS_SUPPLY_V: nxt_rdata = supply_ff;
      OFS_PIN_DIR: nxt_rdata = pin_dir_q;
      OFS_PIN0_SEL: nxt_rdata = pin0_sel_q;
      default: nxt_rdata = RST_ZERO;
    endcase
    if (!i_req.rd_en) begin
      nxt_rdata = rdata_ff;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= RST_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // pin 0 source selection
  always_comb begin
    case (pin0_sel_q[SEL_WIDTH-1:0])
      SRC_OFF: pin0_src = 1'b0; // RQ9
      SRC_USER: pin0_src = i_user_pin_value[0]; // RQ9 RQ19
      SRC_MUTE_BOTH: pin0_src = src_sync[6] & src_sync[5]; // RQ10
      SRC_MUTE_LEFT: pin0_src = src_sync[6]; // RQ10
      SRC_MUTE_RIGHT: pin0_src = src_sync[5]; // RQ10
      SRC_CLK_INVALID: pin0_src = src_sync[4]; // RQ11
      SRC_WARNING: pin0_src = src_sync[3]; // RQ12
      SRC_AUDIO_OUT: pin0_src = src_sync[2]; // RQ13
      SRC_FAULT: pin0_src = src_sync[1]; // RQ14
      SRC_MEM_DATA: pin0_src = src_sync[0]; // RQ15
      default: pin0_src = 1'b0; // RQ16
    endcase
    nxt_pin0 = pin_dir_q[0] ? pin0_src : 1'b0; // RQ21
    nxt_oe = pin_dir_q[PIN_COUNT-1:0]; // RQ8 RQ21
    nxt_addr = i_wide_address_enable ? {addr_high_q, addr_middle_q, addr_low_q}
                                     : {8'h00, addr_middle_q, addr_low_q}; // RQ18
    nxt_opcode = opcode_q; // RQ1
    nxt_boot_src = i_load_from_memory; // RQ17
    nxt_mark = filter_wr_q[BIT_FIRST_COEF]; // RQ6
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin0_ff <= 1'b0;
      oe_ff <= 3'h0;
      addr_ff <= 24'h00_0000;
      opcode_ff <= RST_RD_OPCODE;
      boot_src_ff <= 1'b0;
      mark_ff <= 1'b0;
    end else begin
      pin0_ff <= nxt_pin0;
      oe_ff <= nxt_oe;
      addr_ff <= nxt_addr;
      opcode_ff <= nxt_opcode;
      boot_src_ff <= nxt_boot_src;
      mark_ff <= nxt_mark;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_rvalid = rvalid_ff;
  assign o_memory_read_opcode = opcode_ff;
  assign o_boot_start_addr = addr_ff;
  assign o_boot_from_memory = boot_src_ff;
  assign o_filter_first_coef_mark = mark_ff;
  assign o_pin0_out = pin0_ff;
  assign o_pin0_output_enable = oe_ff[0];
  assign o_pin1_output_enable = oe_ff[1];
  assign o_pin2_output_enable = oe_ff[2];

  chk_opcode_reset: assert property (@(posedge i_ref_clk) // RQ1
    $rose(i_rst_n) |-> opcode_q == RST_RD_OPCODE)
    else $error("opcode not at reset value");
  chk_addr_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ3
    wr_hit(i_req, OFS_ADDR_MIDDLE) |=> addr_middle_q == $past(i_req.wdata))
    else $error("middle address byte not written");
  chk_status_done: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ4
    $rose(done_sync) |=> status_ff[BIT_BOOT_DONE])
    else $error("done flag missed");
  chk_status_reserved: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ20
    status_ff[7:2] == 6'h00 && filter_wr_q[7:1] == 7'h00 && pin_dir_q[7:3] == 5'h00)
    else $error("reserved bits not zero");
  chk_pin_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ21
    !pin_dir_q[0] |=> !o_pin0_out)
    else $error("pin 0 driven while input");
  chk_sel_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ9
    pin0_sel_q[3:0] == SRC_OFF |=> !o_pin0_out)
    else $error("pin 0 not low when off");
  chk_mute_both: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ10
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_MUTE_BOTH
    |=> o_pin0_out == ($past(src_sync[6]) & $past(src_sync[5])))
    else $error("both-mute flag wrong");
  chk_dir_oe: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ8
    wr_hit(i_req, OFS_PIN_DIR) |=> ##1 oe_ff == $past(i_req.wdata[2:0], 2))
    else $error("output enables not following direction");
  chk_narrow_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ18
    !i_wide_address_enable |=> o_boot_start_addr[23:16] == 8'h00)
    else $error("high byte used in narrow mode");
  chk_read_status: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ5
    i_req.rd_en && i_req.addr == OFS_BOOT_STATUS
    |=> o_rvalid && o_rdata[BIT_BOOT_CRC_ERR] == $past(crc_sync, 2))
    else $error("checksum flag read wrong");
  chk_opcode_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ1
    wr_hit(i_req, OFS_RD_OPCODE) |=> opcode_q == $past(i_req.wdata))
    else $error("opcode not written");
  chk_high_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ2
    wr_hit(i_req, OFS_ADDR_HIGH) |=> addr_high_q == $past(i_req.wdata))
    else $error("high address byte not written");
  chk_low_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ3
    wr_hit(i_req, OFS_ADDR_LOW) |=> addr_low_q == $past(i_req.wdata))
    else $error("low address byte not written");
  chk_wide_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ18
    i_wide_address_enable
    |=> o_boot_start_addr == {$past(addr_high_q), $past(addr_middle_q), $past(addr_low_q)})
    else $error("wide start address wrong");
  chk_status_crc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ5
    $rose(crc_sync) |=> status_ff[BIT_BOOT_CRC_ERR])
    else $error("checksum flag missed");
  chk_read_supply: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ7
    i_req.rd_en && i_req.addr == OFS_SUPPLY_V |=> o_rdata == $past(supply_ff))
    else $error("supply code read wrong");
  chk_first_mark: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ6
    wr_hit(i_req, OFS_FILTER_WR)
    |=> ##1 o_filter_first_coef_mark == $past(i_req.wdata[BIT_FIRST_COEF], 2))
    else $error("first coefficient mark wrong");
  chk_boot_source: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ17
    1'b1 |=> o_boot_from_memory == $past(i_load_from_memory))
    else $error("load source not followed");
  chk_user_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ19
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_USER |=> o_pin0_out == $past(i_user_pin_value[0]))
    else $error("user pin value wrong");
  chk_mute_left: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ10
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_MUTE_LEFT |=> o_pin0_out == $past(src_sync[6]))
    else $error("left mute flag wrong");
  chk_mute_right: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ10
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_MUTE_RIGHT |=> o_pin0_out == $past(src_sync[5]))
    else $error("right mute flag wrong");
  chk_clk_invalid: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ11
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_CLK_INVALID |=> o_pin0_out == $past(src_sync[4]))
    else $error("clock invalid flag wrong");
  chk_warning_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ12
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_WARNING |=> o_pin0_out == $past(src_sync[3]))
    else $error("warning indication wrong");
  chk_audio_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ13
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_AUDIO_OUT |=> o_pin0_out == $past(src_sync[2]))
    else $error("serial audio output wrong");
  chk_fault_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ14
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_FAULT |=> o_pin0_out == $past(src_sync[1]))
    else $error("fault indication wrong");
  chk_mem_data: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ15
    pin_dir_q[0] && pin0_sel_q[3:0] == SRC_MEM_DATA |=> o_pin0_out == $past(src_sync[0]))
    else $error("memory data output wrong");
endmodule // cbr_regs

// >>> verification/cbr_status_model.sv
// model of the device sources and config levels feeding the register slice
`timescale 1ns/100ps
module cbr_status_model (
  input wire logic i_ref_clk,
  output cbr_pkg::cbr_src_t o_src,
  output logic o_boot_done,
  output logic o_boot_crc_err,
  output logic [7:0] o_supply_voltage_code,
  output logic [2:0] o_user_pin_value,
  output logic o_load_from_memory,
  output logic o_wide_address_enable
);
  import cbr_pkg::*;
  initial begin
    o_src = '0;
    o_boot_done = 1'b0;
    o_boot_crc_err = 1'b0;
    o_supply_voltage_code = 8'h00;
    o_user_pin_value = 3'h0;
    o_load_from_memory = 1'b0;
    o_wide_address_enable = 1'b0;
  end
  // every level changes on a clock edge, as the rest of the device would
  task automatic set_src(input cbr_src_t s, input logic [2:0] u);
    @(posedge i_ref_clk);
    o_src <= s;
    o_user_pin_value <= u;
  endtask
  task automatic set_status(input logic d, input logic e, input logic [7:0] c);
    @(posedge i_ref_clk);
    o_boot_done <= d;
    o_boot_crc_err <= e;
    o_supply_voltage_code <= c;
  endtask
  task automatic set_cfg(input logic ld, input logic w);
    @(posedge i_ref_clk);
    o_load_from_memory <= ld;
    o_wide_address_enable <= w;
  endtask
endmodule // cbr_status_model

// >>> verification/tb_cbr_regs.sv
// self-checking testbench for the boot and pin select register slice
`timescale 1ns/100ps
module tb_cbr_regs;
  import cbr_pkg::*;
  logic i_ref_clk;
  logic i_rst_n;
  cbr_req_t req;
  cbr_src_t src;
  logic [7:0] rdata, supply, opcode;
  logic [23:0] start_addr;
  logic [2:0] user_pin;
  logic rvalid, boot_done, crc_err, load_mem, wide, from_mem, first_mark;
  logic pin0, oe0, oe1, oe2;
  int miscompares;
  int checks_done;

  cbr_status_model u_cbr_status_model (.i_ref_clk(i_ref_clk), .o_src(src),
    .o_boot_done(boot_done), .o_boot_crc_err(crc_err), .o_supply_voltage_code(supply),
    .o_user_pin_value(user_pin), .o_load_from_memory(load_mem), .o_wide_address_enable(wide));

  cbr_regs u_cbr_regs (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(req),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_boot_done(boot_done), .i_boot_crc_err(crc_err),
    .i_supply_voltage_code(supply), .i_load_from_memory(load_mem),
    .i_wide_address_enable(wide), .i_user_pin_value(user_pin), .i_src(src),
    .o_memory_read_opcode(opcode), .o_boot_start_addr(start_addr),
    .o_boot_from_memory(from_mem), .o_filter_first_coef_mark(first_mark),
    .o_pin0_out(pin0), .o_pin0_output_enable(oe0), .o_pin1_output_enable(oe1),
    .o_pin2_output_enable(oe2));

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic end_of_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk);
    req <= '0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge i_ref_clk);
    req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_ref_clk);
    req <= '0;
    #1;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
      wait_cyc(1);
    end
    if (rvalid !== 1'b1) begin
      miscompares++;
      $display("unexpected read valid expected 1 seen %b", rvalid);
      end_of_test();
    end
    cmp(what, {16'h0000, exp}, {16'h0000, rdata});
  endtask

  function automatic logic exp_pin0(input logic [3:0] s, input cbr_src_t v, input logic u);
    case (s)
      SRC_USER: return u;
      SRC_MUTE_BOTH: return v.mute_left & v.mute_right;
      SRC_MUTE_LEFT: return v.mute_left;
      SRC_MUTE_RIGHT: return v.mute_right;
      SRC_CLK_INVALID: return v.clk_invalid;
      SRC_WARNING: return v.warning_out_n;
      SRC_AUDIO_OUT: return v.serial_audio_out;
      SRC_FAULT: return v.fault_out_n;
      SRC_MEM_DATA: return v.mem_data_out;
      default: return 1'b0;
    endcase
  endfunction

  task automatic t_reset_values();
    rd_chk("opcode", OFS_RD_OPCODE, 8'h03);
    rd_chk("addr high", OFS_ADDR_HIGH, 8'h00);
    rd_chk("addr middle", OFS_ADDR_MIDDLE, 8'h00);
    rd_chk("addr low", OFS_ADDR_LOW, 8'h00);
    rd_chk("boot status", OFS_BOOT_STATUS, 8'h00);
    rd_chk("filter ctrl", OFS_FILTER_WR, 8'h00);
    rd_chk("supply code", OFS_SUPPLY_V, 8'h00);
    rd_chk("pin dir", OFS_PIN_DIR, 8'h00);
    rd_chk("pin0 select", OFS_PIN0_SEL, 8'h00);
    cmp("opcode out", 24'h00_0003, {16'h0000, opcode});
    cmp("pin oe", 24'h00_0000, {21'h0, oe2, oe1, oe0});
  endtask

  task automatic t_rw_masks();
    wr(OFS_RD_OPCODE, 8'ha5);
    wr(OFS_ADDR_HIGH, 8'h12);
    wr(OFS_ADDR_MIDDLE, 8'h34);
    wr(OFS_ADDR_LOW, 8'h56);
    wr(OFS_FILTER_WR, 8'hff);
    wr(OFS_PIN_DIR, 8'hf8);
    wr(OFS_PIN0_SEL, 8'hf2);
    rd_chk("opcode", OFS_RD_OPCODE, 8'ha5);
    rd_chk("addr high", OFS_ADDR_HIGH, 8'h12);
    rd_chk("addr middle", OFS_ADDR_MIDDLE, 8'h34);
    rd_chk("addr low", OFS_ADDR_LOW, 8'h56);
    rd_chk("filter ctrl", OFS_FILTER_WR, 8'h01);
    rd_chk("pin dir", OFS_PIN_DIR, 8'h00);
    rd_chk("pin0 select", OFS_PIN0_SEL, 8'h02);
    u_cbr_status_model.set_cfg(1'b1, 1'b1);
    wait_cyc(3);
    cmp("start addr wide", 24'h12_3456, start_addr);
    cmp("opcode out", 24'h00_00a5, {16'h0000, opcode});
    cmp("first coef", 24'h00_0001, {23'h0, first_mark});
    cmp("from memory", 24'h00_0001, {23'h0, from_mem});
    u_cbr_status_model.set_cfg(1'b0, 1'b0);
    wr(OFS_FILTER_WR, 8'h00);
    wait_cyc(3);
    cmp("start addr narrow", 24'h00_3456, start_addr);
    cmp("from memory", 24'h00_0000, {23'h0, from_mem});
    cmp("first coef", 24'h00_0000, {23'h0, first_mark});
  endtask

  task automatic t_read_only();
    u_cbr_status_model.set_status(1'b1, 1'b1, 8'hdf);
    wait_cyc(4);
    rd_chk("boot status", OFS_BOOT_STATUS, 8'h03);
    rd_chk("supply code", OFS_SUPPLY_V, 8'hdf);
    wr(OFS_BOOT_STATUS, 8'h00);
    wr(OFS_SUPPLY_V, 8'h00);
    wr(8'h70, 8'hff);
    rd_chk("boot status", OFS_BOOT_STATUS, 8'h03);
    rd_chk("supply code", OFS_SUPPLY_V, 8'hdf);
    rd_chk("unmapped", 8'h70, 8'h00);
    rd_chk("opcode", OFS_RD_OPCODE, 8'ha5);
    u_cbr_status_model.set_status(1'b1, 1'b0, 8'h25);
    wait_cyc(4);
    rd_chk("boot status", OFS_BOOT_STATUS, 8'h01);
  endtask

  task automatic t_pin0_mux();
    // reserved selector codes are left out on purpose
    logic [3:0] codes [10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hb, 4'hc};
    // every source bit gets its own column across the patterns
    logic [6:0] pats [4] = '{7'h0f, 7'h33, 7'h55, 7'h60};
    logic e;
    wr(OFS_PIN_DIR, 8'h01);
    wait_cyc(2);
    cmp("pin oe", 24'h00_0001, {21'h0, oe2, oe1, oe0});
    foreach (codes[i]) begin
      wr(OFS_PIN0_SEL, {4'h0, codes[i]});
      foreach (pats[k]) begin
        u_cbr_status_model.set_src(pats[k], {3{~pats[k][4]}});
        wait_cyc(5);
        e = exp_pin0(codes[i], pats[k], ~pats[k][4]);
        cmp("pin0 out", {23'h0, e}, {23'h0, pin0});
      end
    end
    // source high so that the input direction must pull the pin data low
    u_cbr_status_model.set_src(7'h7f, 3'h7);
    wait_cyc(5);
    cmp("pin0 driven", 24'h00_0001, {23'h0, pin0});
    wr(OFS_PIN_DIR, 8'h06);
    wait_cyc(3);
    cmp("pin oe", 24'h00_0006, {21'h0, oe2, oe1, oe0});
    cmp("pin0 out input", 24'h00_0000, {23'h0, pin0});
  endtask

  initial begin
    miscompares = 0;
    checks_done = 0;
    i_rst_n = 1'b0;
    req = '0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_reset_values();
    t_rw_masks();
    t_read_only();
    t_pin0_mux();
    end_of_test();
  end
endmodule // tb_cbr_regs
